// ===== uad_defs.svh
// register map, field positions, reset values and timing counts of the serial receiver block
`ifndef UAD_DEFS_SVH
`define UAD_DEFS_SVH
// register indices on the local register port
`define UAD_A_RXDATA   3'h0
`define UAD_A_RXSTAT   3'h1
`define UAD_A_BAUD     3'h2
`define UAD_A_TXSTAT   3'h3
`define UAD_A_TXDATA   3'h4
// rx_status_ctrl fields
`define UAD_RS_SERIAL_PORT_ENABLE    7
`define UAD_RS_RX9     6
`define UAD_RS_SINGLE_RECEIVE_ENABLE    5
`define UAD_RS_CONTINUOUS_RECEIVE_ENABLE    4
`define UAD_RS_ADDRESS_DETECT_ENABLE   3
// tx_status_ctrl fields
`define UAD_TS_CLOCK_SOURCE_SELECT    7
`define UAD_TS_TX9     6
`define UAD_TS_TX_PATH_ENABLE    5
`define UAD_TS_SYNC    4
`define UAD_TS_HIGH_SPEED_BAUD_SELECT    2
`define UAD_TS_TX_NINTH_BIT    0
// reset values
`define UAD_BYTE_RESET 8'h00
// timing counts, each as a terminal count (count minus one)
`define UAD_OVS_LAST   4'hF
`define UAD_OVS_HALF   4'h7
`define UAD_LOW_PRE    2'h3
`define UAD_SCK_HALF   4'h1
// character lengths
`define UAD_RX_BITS8   4'h8
`define UAD_RX_BITS9   4'h9
`define UAD_TX_BITS8   4'hA
`define UAD_TX_BITS9   4'hB
`endif

// ===== uad_pkg.sv
// types shared by the serial receiver block
package uad_pkg;
    typedef enum logic [3:0] {
        RX_IDLE  = 4'h1,
        RX_START = 4'h2,
        RX_DATA  = 4'h4,
        RX_STOP  = 4'h8
    } uad_rx_state_type;
endpackage

// ===== uad_top.sv
// serial unit with 9-bit address detection and its status/control registers
`timescale 1ns/1ps
`include "uad_defs.svh"

module uad_top #(
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic       REF_CLK_IN,
    input  wire logic       SRST_IN,
    // register port
    input  wire logic [2:0] REG_ADDR_IN,
    input  wire logic [7:0] REG_WDATA_IN,
    input  wire logic       REG_WR_IN,
    input  wire logic       REG_RD_IN,
    output logic      [7:0] REG_RDATA_OUT,
    // receive interrupt
    input  wire logic       RX_IRQ_ENABLE_IN,
    output logic            RX_PENDING_OUT,
    output logic            RX_IRQ_OUT,
    // rx_data_pin, two-way
    input  wire logic       RX_DATA_PIN_IN,
    output logic            RX_DATA_PIN_OUT,
    output logic            RX_DATA_PIN_OE_N_OUT,
    // tx_clock_pin, two-way
    input  wire logic       TX_CLOCK_PIN_IN,
    output logic            TX_CLOCK_PIN_OUT,
    output logic            TX_CLOCK_PIN_OE_N_OUT
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [PW-1:0] LASTP = PW'(DEPTH - 1);

    // control bits
    logic       serial_port_enable_r, rx9_r, single_receive_enable_r, continuous_receive_enable_r, address_detect_enable_r;
    logic       clock_source_select_r, tx9_r, tx_path_enable_r, sync_r, high_speed_baud_select_r, tx_ninth_bit_r;
    logic [7:0] baud_r;
    logic       single_receive_enable_clr;
    // pin synchronisers
    logic       rx_meta_r, rx_s_r, ck_meta_r, ck_s_r, ck_prev_r;
    // baud timer
    logic [1:0] pre_cnt_r;
    logic [7:0] div_cnt_r;
    logic       sub_tick_r;
    logic [1:0] pre_lim;
    // receiver
    uad_pkg::uad_rx_state_type state_r;
    logic [3:0] sub_cnt_r, bit_cnt_r, nbits;
    logic [8:0] shift_r;
    logic       sck_r, done_r, done_d9_r, done_fe_r;
    logic [7:0] done_data_r;
    logic       rx_on_async, rx_on_sync, sync_master, sample_edge;
    // buffer
    logic [7:0] data_m [DEPTH];
    logic       d9_m   [DEPTH];
    logic       fe_m   [DEPTH];
    logic [PW-1:0] wr_ptr_r, rd_ptr_r;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic       overrun_error_flag_r, accept, reject, push, ovr, pop;
    // transmitter
    logic [7:0] hold_data_r;
    logic       hold_v_r, tx_allow, tx_go, tx_empty;
    logic [10:0] tx_sh_r;
    logic [3:0] tx_cnt_r, tx_sub_r;
    // outputs
    logic [7:0] rdata_r;
    logic       pend_r, irq_r, tx_pin_r, tx_oe_n_r, rx_oe_n_r;
    logic       eng_rst, baud_wr;

    // clearing the port enable resets the engine but keeps software's settings
    assign eng_rst = SRST_IN | ~serial_port_enable_r;
    assign baud_wr = REG_WR_IN & (REG_ADDR_IN == `UAD_A_BAUD);
    assign pop     = REG_RD_IN & (REG_ADDR_IN == `UAD_A_RXDATA) & (cnt_r != '0);

    // receive control bits; a write to another register must not swallow the single-receive clear
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            {serial_port_enable_r, rx9_r, single_receive_enable_r, continuous_receive_enable_r, address_detect_enable_r} <= 5'h00;
        end else if (REG_WR_IN && REG_ADDR_IN == `UAD_A_RXSTAT) begin
            serial_port_enable_r  <= REG_WDATA_IN[`UAD_RS_SERIAL_PORT_ENABLE];
            rx9_r   <= REG_WDATA_IN[`UAD_RS_RX9];
            single_receive_enable_r  <= REG_WDATA_IN[`UAD_RS_SINGLE_RECEIVE_ENABLE];
            continuous_receive_enable_r  <= REG_WDATA_IN[`UAD_RS_CONTINUOUS_RECEIVE_ENABLE];
            address_detect_enable_r <= REG_WDATA_IN[`UAD_RS_ADDRESS_DETECT_ENABLE];
        end else if (single_receive_enable_clr) begin
            single_receive_enable_r <= 1'b0;
        end
    end

    // transmit control bits
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            {clock_source_select_r, tx9_r, tx_path_enable_r, sync_r, high_speed_baud_select_r, tx_ninth_bit_r} <= 6'h00;
        end else if (REG_WR_IN && REG_ADDR_IN == `UAD_A_TXSTAT) begin
            clock_source_select_r  <= REG_WDATA_IN[`UAD_TS_CLOCK_SOURCE_SELECT];
            tx9_r   <= REG_WDATA_IN[`UAD_TS_TX9];
            tx_path_enable_r  <= REG_WDATA_IN[`UAD_TS_TX_PATH_ENABLE];
            sync_r  <= REG_WDATA_IN[`UAD_TS_SYNC];
            high_speed_baud_select_r  <= REG_WDATA_IN[`UAD_TS_HIGH_SPEED_BAUD_SELECT];
            tx_ninth_bit_r  <= REG_WDATA_IN[`UAD_TS_TX_NINTH_BIT];
        end
    end

    // baud divisor; the same write restarts the baud timer
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            baud_r <= `UAD_BYTE_RESET;
        end else if (baud_wr) begin
            baud_r <= REG_WDATA_IN;
        end
    end

    // two flip-flops on each pin before any logic looks at it
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            {rx_meta_r, rx_s_r, ck_meta_r, ck_s_r, ck_prev_r} <= 5'h1F;
        end else begin
            rx_meta_r <= RX_DATA_PIN_IN;
            rx_s_r    <= rx_meta_r;
            ck_meta_r <= TX_CLOCK_PIN_IN;
            ck_s_r    <= ck_meta_r;
            ck_prev_r <= ck_s_r;
        end
    end

    // baud timer: sub-tick every (divisor+1) or 4*(divisor+1) clocks, 16 per async bit
    assign pre_lim = (sync_r | high_speed_baud_select_r) ? 2'h0 : `UAD_LOW_PRE;
    always_ff @(posedge REF_CLK_IN) begin
        if (eng_rst || baud_wr) begin
            pre_cnt_r  <= 2'h0;
            div_cnt_r  <= 8'h00;
            sub_tick_r <= 1'b0;
        end else begin
            sub_tick_r <= 1'b0;
            if (div_cnt_r == baud_r) begin
                div_cnt_r <= 8'h00;
                if (pre_cnt_r == pre_lim) begin
                    pre_cnt_r  <= 2'h0;
                    sub_tick_r <= 1'b1;
                end else begin
                    pre_cnt_r <= pre_cnt_r + 2'h1;
                end
            end else begin
                div_cnt_r <= div_cnt_r + 8'h01;
            end
        end
    end

    // receiver enables; overrun blocks both modes until cleared
    assign rx_on_async = ~sync_r & continuous_receive_enable_r & ~overrun_error_flag_r;
    assign sync_master = clock_source_select_r;
    assign rx_on_sync  = sync_r & (continuous_receive_enable_r | (single_receive_enable_r & sync_master)) & ~overrun_error_flag_r;
    assign nbits       = rx9_r ? `UAD_RX_BITS9 : `UAD_RX_BITS8;
    // master samples when its own clock rises, slave on the external rising edge
    assign sample_edge = sync_master ? (sub_tick_r && sub_cnt_r == `UAD_SCK_HALF && !sck_r)
                                     : (ck_s_r & ~ck_prev_r);
    // continuous receive wins: single receive clears only when it alone was active
    assign single_receive_enable_clr = done_r & sync_r & sync_master & ~continuous_receive_enable_r;

    // character recovery: start check at mid-bit, then one sample per bit
    always_ff @(posedge REF_CLK_IN) begin
        if (eng_rst) begin
            state_r     <= uad_pkg::RX_IDLE;
            sub_cnt_r   <= 4'h0;
            bit_cnt_r   <= 4'h0;
            shift_r     <= 9'h000;
            sck_r       <= 1'b0;
            done_r      <= 1'b0;
            done_d9_r   <= 1'b0;
            done_fe_r   <= 1'b0;
            done_data_r <= 8'h00;
        end else begin
            done_r <= 1'b0;
            case (state_r)
                uad_pkg::RX_IDLE: begin
                    sub_cnt_r <= 4'h0;
                    bit_cnt_r <= 4'h0;
                    sck_r     <= 1'b0;
                    if (rx_on_sync) begin
                        state_r <= uad_pkg::RX_DATA;
                    end else if (rx_on_async && !rx_s_r) begin
                        state_r <= uad_pkg::RX_START;
                    end
                end
                uad_pkg::RX_START: begin
                    if (!rx_on_async) begin
                        state_r <= uad_pkg::RX_IDLE;
                    end else if (sub_tick_r) begin
                        if (sub_cnt_r == `UAD_OVS_HALF) begin
                            sub_cnt_r <= 4'h0;
                            // a glitch that is high again at mid-bit is dropped silently
                            state_r <= rx_s_r ? uad_pkg::RX_IDLE : uad_pkg::RX_DATA;
                        end else begin
                            sub_cnt_r <= sub_cnt_r + 4'h1;
                        end
                    end
                end
                uad_pkg::RX_DATA: begin
                    if (sync_r ? !rx_on_sync : !rx_on_async) begin
                        state_r <= uad_pkg::RX_IDLE;
                    end else if (sync_r) begin
                        if (sync_master && sub_tick_r) begin
                            sub_cnt_r <= (sub_cnt_r == `UAD_SCK_HALF) ? 4'h0 : sub_cnt_r + 4'h1;
                            if (sub_cnt_r == `UAD_SCK_HALF) begin
                                sck_r <= ~sck_r;
                            end
                        end
                        if (sample_edge) begin
                            shift_r   <= {rx_s_r, shift_r[8:1]};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                            if (bit_cnt_r == nbits - 4'h1) begin
                                state_r     <= uad_pkg::RX_IDLE;
                                done_r      <= 1'b1;
                                done_fe_r   <= 1'b0;
                                done_d9_r   <= rx9_r & rx_s_r;
                                done_data_r <= rx9_r ? shift_r[8:1] : {rx_s_r, shift_r[8:2]};
                            end
                        end
                    end else if (sub_tick_r) begin
                        if (sub_cnt_r == `UAD_OVS_LAST) begin
                            sub_cnt_r <= 4'h0;
                            shift_r   <= {rx_s_r, shift_r[8:1]};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                            if (bit_cnt_r == nbits - 4'h1) begin
                                state_r <= uad_pkg::RX_STOP;
                            end
                        end else begin
                            sub_cnt_r <= sub_cnt_r + 4'h1;
                        end
                    end
                end
                uad_pkg::RX_STOP: begin
                    if (!rx_on_async) begin
                        state_r <= uad_pkg::RX_IDLE;
                    end else if (sub_tick_r) begin
                        if (sub_cnt_r == `UAD_OVS_LAST) begin
                            state_r     <= uad_pkg::RX_IDLE;
                            done_r      <= 1'b1;
                            done_fe_r   <= ~rx_s_r;
                            done_d9_r   <= rx9_r & shift_r[8];
                            done_data_r <= rx9_r ? shift_r[7:0] : shift_r[8:1];
                        end else begin
                            sub_cnt_r <= sub_cnt_r + 4'h1;
                        end
                    end
                end
                default: state_r <= uad_pkg::RX_IDLE;
            endcase
        end
    end

    // address filter applies only to asynchronous 9-bit reception
    assign reject = done_r & address_detect_enable_r & rx9_r & ~sync_r & ~done_d9_r;
    assign accept = done_r & ~reject;
    assign push   = accept & (cnt_r != FULL);
    assign ovr    = accept & (cnt_r == FULL);

    // DEPTH-entry receive buffer (two by default), one write port per entry
    for (genvar g = 0; g < DEPTH; g++) begin : g_entry
        always_ff @(posedge REF_CLK_IN) begin
            if (eng_rst) begin
                data_m[g] <= 8'h00;
                d9_m[g]   <= 1'b0;
                fe_m[g]   <= 1'b0;
            end else if (push && wr_ptr_r == PW'(g)) begin
                data_m[g] <= done_data_r;
                d9_m[g]   <= done_d9_r;
                fe_m[g]   <= done_fe_r;
            end
        end
    end

    // buffer pointers and fill count
    always_comb begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + CW'(1);
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - CW'(1);
        end
    end
    always_ff @(posedge REF_CLK_IN) begin
        if (eng_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == LASTP) ? '0 : wr_ptr_r + PW'(1);
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == LASTP) ? '0 : rd_ptr_r + PW'(1);
            end
        end
    end

    // overrun: a new overrun wins over the clear by continuous receive
    always_ff @(posedge REF_CLK_IN) begin
        if (eng_rst) begin
            overrun_error_flag_r <= 1'b0;
        end else if (ovr) begin
            overrun_error_flag_r <= 1'b1;
        end else if (!continuous_receive_enable_r) begin
            overrun_error_flag_r <= 1'b0;
        end
    end

    // transmitter: async frames only; synchronous receive enables take the pins
    assign tx_allow = tx_path_enable_r & ~(sync_r & (single_receive_enable_r | continuous_receive_enable_r));
    assign tx_go    = tx_allow & ~sync_r & hold_v_r & (tx_cnt_r == 4'h0);
    assign tx_empty = (tx_cnt_r == 4'h0);
    always_ff @(posedge REF_CLK_IN) begin
        if (eng_rst) begin
            hold_data_r <= 8'h00;
            hold_v_r    <= 1'b0;
        end else if (REG_WR_IN && REG_ADDR_IN == `UAD_A_TXDATA) begin
            hold_data_r <= REG_WDATA_IN;
            hold_v_r    <= 1'b1;
        end else if (tx_go) begin
            hold_v_r <= 1'b0;
        end
    end
    always_ff @(posedge REF_CLK_IN) begin
        if (eng_rst) begin
            tx_sh_r  <= 11'h7FF;
            tx_cnt_r <= 4'h0;
            tx_sub_r <= 4'h0;
        end else if (tx_go) begin
            tx_sh_r  <= {1'b1, tx9_r ? tx_ninth_bit_r : 1'b1, hold_data_r, 1'b0};
            tx_cnt_r <= tx9_r ? `UAD_TX_BITS9 : `UAD_TX_BITS8;
            tx_sub_r <= 4'h0;
        end else if (!tx_empty && sub_tick_r) begin
            tx_sub_r <= tx_sub_r + 4'h1;
            if (tx_sub_r == `UAD_OVS_LAST) begin
                tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
                tx_cnt_r <= tx_cnt_r - 4'h1;
            end
        end
    end

    // pin drive: the unit decides driving versus released by itself
    always_ff @(posedge REF_CLK_IN) begin
        if (eng_rst) begin
            tx_pin_r  <= 1'b1;
            tx_oe_n_r <= 1'b1;
            rx_oe_n_r <= 1'b1;
        end else begin
            tx_pin_r  <= sync_r ? sck_r : (tx_empty | tx_sh_r[0]);
            tx_oe_n_r <= sync_r & ~sync_master;
            rx_oe_n_r <= 1'b1;                  // data pin is always an input here
        end
    end

    // pending and gated interrupt, both registered
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            pend_r <= 1'b0;
            irq_r  <= 1'b0;
        end else begin
            pend_r <= (cnt_r != '0);
            irq_r  <= (cnt_r != '0) & RX_IRQ_ENABLE_IN;
        end
    end

    // read data stands only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN || !REG_RD_IN) begin
            rdata_r <= 8'h00;
        end else begin
            case (REG_ADDR_IN)
                `UAD_A_RXDATA: rdata_r <= data_m[rd_ptr_r];
                `UAD_A_RXSTAT: rdata_r <= {serial_port_enable_r, rx9_r, single_receive_enable_r, continuous_receive_enable_r, address_detect_enable_r,
                                           fe_m[rd_ptr_r], overrun_error_flag_r, d9_m[rd_ptr_r]};
                `UAD_A_BAUD:   rdata_r <= baud_r;
                `UAD_A_TXSTAT: rdata_r <= {clock_source_select_r, tx9_r, tx_path_enable_r, sync_r, 1'b0,
                                           high_speed_baud_select_r, tx_empty, tx_ninth_bit_r};
                default:       rdata_r <= 8'h00;
            endcase
        end
    end

    assign REG_RDATA_OUT         = rdata_r;
    assign RX_PENDING_OUT        = pend_r;
    assign RX_IRQ_OUT            = irq_r;
    assign RX_DATA_PIN_OUT       = 1'b1 & rx_oe_n_r;
    assign RX_DATA_PIN_OE_N_OUT  = rx_oe_n_r;
    assign TX_CLOCK_PIN_OUT      = tx_pin_r;
    assign TX_CLOCK_PIN_OE_N_OUT = tx_oe_n_r;

    // checks on the block's own behaviour
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (SRST_IN);

    sequence seq_clean_take;
        done_r && !address_detect_enable_r && cnt_r == '0 && !pop && serial_port_enable_r;
    endsequence
    sequence seq_flag_up;
        ##2 RX_PENDING_OUT;
    endsequence

    AST_ACCEPT_ALL: assert property (disable iff (eng_rst) seq_clean_take |-> seq_flag_up)
        else $error("character not flagged with address detect off");
    AST_REJECT_KEEPS: assert property (reject && !pop |=> cnt_r == $past(cnt_r) && !overrun_error_flag_r)
        else $error("rejected character changed the buffer");
    AST_ADDR_NINTH: assert property (push && address_detect_enable_r && rx9_r && !sync_r |-> done_d9_r)
        else $error("address mode buffered a character with ninth bit zero");
    AST_IRQ_GATE: assert property (RX_IRQ_OUT == (RX_PENDING_OUT && $past(RX_IRQ_ENABLE_IN)))
        else $error("interrupt not gated by enable");
    AST_OVERRUN: assert property (disable iff (eng_rst) ovr |=> overrun_error_flag_r ##1 (!push || !continuous_receive_enable_r))
        else $error("overrun not flagged or reception not blocked");
    AST_OVERRUN_ERROR_FLAG_CLEAR: assert property (!continuous_receive_enable_r && !ovr && serial_port_enable_r |=> !overrun_error_flag_r)
        else $error("overrun not cleared by continuous receive off");
    AST_TX_BUSY: assert property (disable iff (eng_rst) tx_go |=> !tx_empty [*8])
        else $error("shift empty status wrong during a frame");
    AST_SINGLE_RECEIVE_ENABLE_SELF_CLEAR: assert property (single_receive_enable_clr && !(REG_WR_IN && REG_ADDR_IN == `UAD_A_RXSTAT) |=> !single_receive_enable_r)
        else $error("single receive did not clear after completion");
    AST_PORT_OFF: assert property (!serial_port_enable_r |=> TX_CLOCK_PIN_OE_N_OUT && RX_DATA_PIN_OE_N_OUT && cnt_r == '0)
        else $error("disabled port still drives or holds data");
    AST_READ_WINDOW: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 8'h00)
        else $error("read data outside its cycle");
    AST_TX_OVERRIDE: assert property (sync_r && (single_receive_enable_r || continuous_receive_enable_r) |-> !tx_go)
        else $error("transmit not overridden by receive enables");
endmodule // uad_top

// ===== uad_line_node.sv
// far-side node on the shared serial line, sending 8- or 9-bit characters
`timescale 1ns/1ps
module uad_line_node #(
    parameter int BIT_CLKS = 16
) (
    input  wire logic clk_in,
    output logic      line_out
);
    // the line rests at mark between frames, as a biased bus does
    initial line_out = 1'b1;
    // start bit, data lsb first, optional ninth bit, stop bit, one idle bit as gap
    task automatic send(input logic [8:0] d, input logic nine, input logic stop);
        logic [11:0] f;
        f = nine ? {1'b1, stop, d, 1'b0} : {1'b0, 1'b1, stop, d[7:0], 1'b0};
        for (int i = 0; i < (nine ? 12 : 11); i++) begin
            line_out <= f[i];
            repeat (BIT_CLKS) @(posedge clk_in);
        end
    endtask
endmodule // uad_line_node

// ===== tb.sv
// self-checking bench for the serial receiver with address detection
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic irq_en = 1'b0;
    logic rd_seen = 1'b0;
    logic line;
    logic [7:0] rdata;
    logic pend, irq, rx_o, rx_oe_n, tx_o, tx_oe_n;
    logic [8:0] c [4];
    logic [7:0] exp_q [$];
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    always #4 clk = ~clk;
    uad_line_node node_u (.clk_in(clk), .line_out(line));
    uad_top dut_u (.REF_CLK_IN(clk), .SRST_IN(srst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .RX_IRQ_ENABLE_IN(irq_en),
        .RX_PENDING_OUT(pend), .RX_IRQ_OUT(irq), .RX_DATA_PIN_IN(line), .RX_DATA_PIN_OUT(rx_o),
        .RX_DATA_PIN_OE_N_OUT(rx_oe_n), .TX_CLOCK_PIN_IN(1'b1), .TX_CLOCK_PIN_OUT(tx_o),
        .TX_CLOCK_PIN_OE_N_OUT(tx_oe_n));
    task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // one-cycle strobes; a quiet cycle follows so no strobe is assigned twice in a step
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rreg(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        addr <= a; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0;
        @(posedge clk);
    endtask
    // pending and interrupt are checked once the character has settled in the buffer
    task automatic chk_pend(input logic p);
        repeat (24) @(posedge clk);
        check("pending", {7'h00, pend}, {7'h00, p});
        check("irq", {7'h00, irq}, {7'h00, p & irq_en});
    endtask
    // read data stands only in the cycle after the strobe, so compare it mid-cycle there
    always @(posedge clk) rd_seen <= rd;
    always @(negedge clk) if (rd_seen) check("rdata", rdata, exp_q.pop_front());
    // hang guard: the whole sequence needs well under this many cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        void'($urandom(67));
        foreach (c[i]) c[i] = 9'($urandom);
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        irq_en <= 1'($urandom);
        @(posedge clk);
        rreg(3'h1, 8'h00);
        rreg(3'h3, 8'h02);
        rreg(3'h5, 8'h00);
        wreg(3'h2, 8'h00);
        wreg(3'h3, 8'h0C); // high speed timing; bit 3 written but unimplemented
        rreg(3'h3, 8'h06);
        wreg(3'h1, 8'hDF); // read-only low bits written as ones are ignored
        rreg(3'h1, 8'hD8);
        check("rx_oe_n", {7'h00, rx_oe_n}, 8'h01);
        check("tx_oe_n", {7'h00, tx_oe_n}, 8'h00);
        check("rx_line", {7'h00, rx_o}, 8'h01);
        // a data character with bad stop is dropped without touching any flag
        node_u.send({1'b0, c[0][7:0]}, 1'b1, 1'b0);
        chk_pend(1'b0);
        node_u.send({1'b1, c[1][7:0]}, 1'b1, 1'b1);
        chk_pend(1'b1);
        rreg(3'h1, 8'hD9);
        rreg(3'h0, c[1][7:0]);
        chk_pend(1'b0);
        wreg(3'h1, 8'hD0); // address matched: software drops detection before the next stop
        // three back-to-back characters: second has a framing error, third overruns
        node_u.send({1'b0, c[2][7:0]}, 1'b1, 1'b1);
        node_u.send(c[3], 1'b1, 1'b0);
        node_u.send(c[0], 1'b1, 1'b1);
        chk_pend(1'b1);
        rreg(3'h1, 8'hD2);
        rreg(3'h0, c[2][7:0]);
        rreg(3'h1, {5'h1A, 1'b1, 1'b1, c[3][8]});
        rreg(3'h0, c[3][7:0]);
        chk_pend(1'b0);
        wreg(3'h1, 8'hC0); // clearing continuous receive clears overrun
        wreg(3'h1, 8'hD0);
        node_u.send({1'b0, c[1][7:0]}, 1'b1, 1'b1);
        chk_pend(1'b1);
        rreg(3'h1, 8'hD0);
        rreg(3'h0, c[1][7:0]);
        // one async frame: shift register fills, line shows the start bit, then drains
        wreg(3'h3, 8'h24);
        wreg(3'h4, 8'($urandom));
        rreg(3'h3, 8'h24);
        check("tx_line", {7'h00, tx_o}, 8'h00);
        repeat (200) @(posedge clk);
        rreg(3'h3, 8'h26);
        check("tx_line", {7'h00, tx_o}, 8'h01);
        repeat (4) @(posedge clk);
        test_done();
    end
endmodule // tb
